// File: verilog/spi_port_pkg.sv
package spi_port_pkg;

    // ------------------------------------------------------------
    // register indices, byte address is four times the index
    // ------------------------------------------------------------
    localparam int unsigned PADDR_W   = 8;
    localparam logic [5:0]  IDX_CTL   = 6'h00;
    localparam logic [5:0]  IDX_RATE  = 6'h06;
    localparam logic [5:0]  IDX_STAT  = 6'h0A;
    localparam logic [5:0]  IDX_RXBUF = 6'h0C;
    localparam logic [5:0]  IDX_TXBUF = 6'h0E;
    localparam logic [5:0]  IDX_IE    = 6'h1A;
    localparam logic [5:0]  IDX_IFG   = 6'h1C;
    localparam logic [5:0]  IDX_IV    = 6'h1E;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned CTL_SOFT_RESET_BIT = 0;
    localparam int unsigned CTL_STE_MODE_BIT   = 1;
    localparam int unsigned CTL_MODE_LSB       = 9;
    localparam int unsigned CTL_MASTER_BIT     = 11;
    localparam int unsigned CTL_SEVEN_BIT      = 12;
    localparam int unsigned STAT_LOOPBACK_BIT  = 7;
    localparam int unsigned STAT_CONFLICT_BIT  = 6;
    localparam int unsigned STAT_OVERRUN_BIT   = 5;
    localparam int unsigned STAT_SPARE_LSB     = 1;
    localparam int unsigned IFG_RX_BIT         = 0;
    localparam int unsigned IFG_TX_BIT         = 1;

    // ------------------------------------------------------------
    // reset values, masks and codes
    // ------------------------------------------------------------
    localparam logic [15:0] CTL_RESET      = 16'h0001;
    localparam logic [15:0] CTL_WRITE_MASK = 16'hFFC3;
    localparam logic [15:0] RATE_RESET     = 16'h0000;
    localparam logic [1:0]  IE_RESET       = 2'h0;
    localparam logic [1:0]  IFG_RESET      = 2'h2;
    localparam logic [15:0] IV_NONE        = 16'h0000;
    localparam logic [15:0] IV_RX          = 16'h0002;
    localparam logic [15:0] IV_TX          = 16'h0004;
    localparam logic [1:0]  MODE_3PIN      = 2'h0;
    localparam logic [1:0]  MODE_4PIN_HIGH = 2'h1;
    localparam logic [1:0]  MODE_4PIN_LOW  = 2'h2;
    localparam logic [3:0]  CHAR_LAST_8    = 4'h7;
    localparam logic [3:0]  CHAR_LAST_7    = 4'h6;

endpackage

// File: verilog/spi_port.sv
`timescale 1ns/1ps
module spi_port (
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_sclk,
    input  wire logic        i_data_in,
    input  wire logic        i_ste,
    output logic             o_sclk,
    output logic             o_sclk_oe,
    output logic             o_data_out,
    output logic             o_data_oe,
    output logic             o_transfer_active,
    output logic             o_irq_request
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic {
        XFER_IDLE,
        XFER_SHIFT
    } xfer_state_t;

    typedef struct packed {
        logic [15:0] ctl;
        logic [15:0] bit_clock_divider;
        logic        loopback_enable;
        logic        bus_conflict_flag;
        logic        overrun_flag;
        logic [3:0]  stat_spare;
        logic [7:0]  rx_char;
        logic [7:0]  tx_char;
        logic        tx_loaded;
        logic [1:0]  irq_en;
        logic [1:0]  irq_flag;
        xfer_state_t xfer;
        logic [7:0]  tx_shift;
        logic [7:0]  rx_shift;
        logic [3:0]  bit_cnt;
        logic [15:0] div_cnt;
        logic        bit_clk;
        logic        sclk_s1;
        logic        sclk_s2;
        logic        sclk_s3;
        logic        din_s1;
        logic        din_s2;
        logic        ste_s1;
        logic        ste_s2;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        sclk_out;
        logic        sclk_oe;
        logic        dout;
        logic        dout_oe;
        logic        busy;
        logic        irq;
    } port_state_t;

    localparam port_state_t ST_RESET = '{
        ctl:               spi_port_pkg::CTL_RESET,
        bit_clock_divider: spi_port_pkg::RATE_RESET,
        irq_en:            spi_port_pkg::IE_RESET,
        irq_flag:          spi_port_pkg::IFG_RESET,
        xfer:              XFER_IDLE,
        default:           '0
    };

    port_state_t st_reg;
    port_state_t st_next;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic reg_hit(input logic [7:0] addr, input logic [5:0] idx);
        reg_hit = (addr[1:0] == 2'h0) && (addr[7:2] == idx);
    endfunction

    function automatic logic reg_mapped(input logic [7:0] addr);
        reg_mapped = reg_hit(addr, spi_port_pkg::IDX_CTL)   || reg_hit(addr, spi_port_pkg::IDX_RATE)
                  || reg_hit(addr, spi_port_pkg::IDX_STAT)  || reg_hit(addr, spi_port_pkg::IDX_RXBUF)
                  || reg_hit(addr, spi_port_pkg::IDX_TXBUF) || reg_hit(addr, spi_port_pkg::IDX_IE)
                  || reg_hit(addr, spi_port_pkg::IDX_IFG)   || reg_hit(addr, spi_port_pkg::IDX_IV);
    endfunction

    logic        soft_hold;
    logic        seven_bit_select;
    logic        master;
    logic [1:0]  port_mode;
    logic        four_pin;
    logic        ste_active;
    logic        slave_en;
    logic        conflict_now;
    logic [15:0] period_m1;
    logic        tick;
    logic        shifting;
    logic        edge_rise;
    logic        edge_fall;
    logic        rx_in;
    logic [3:0]  char_last;
    logic        acc_done;
    logic        wr;
    logic        rd;
    logic [1:0]  pending;
    logic [15:0] iv_code;
    logic [15:0] rd_val;
    logic [7:0]  rx_sampled;

    assign soft_hold        = st_reg.ctl[spi_port_pkg::CTL_SOFT_RESET_BIT];
    assign seven_bit_select = st_reg.ctl[spi_port_pkg::CTL_SEVEN_BIT];
    assign master           = st_reg.ctl[spi_port_pkg::CTL_MASTER_BIT];
    assign port_mode        = st_reg.ctl[spi_port_pkg::CTL_MODE_LSB +: 2];
    assign four_pin         = (port_mode == spi_port_pkg::MODE_4PIN_HIGH)
                           || (port_mode == spi_port_pkg::MODE_4PIN_LOW);
    assign ste_active       = (port_mode == spi_port_pkg::MODE_4PIN_HIGH) ? st_reg.ste_s2 : ~st_reg.ste_s2;
    assign slave_en         = ~master & ~soft_hold & (~four_pin | ste_active);
    // another master holding the select line while we drive the bus
    assign conflict_now     = master & four_pin & ~st_reg.ctl[spi_port_pkg::CTL_STE_MODE_BIT]
                           & ste_active & ~soft_hold;
    assign period_m1        = (st_reg.bit_clock_divider == 16'h0000) ? 16'h0000
                           : st_reg.bit_clock_divider - 16'h0001;
    assign tick             = (st_reg.div_cnt == period_m1);
    assign shifting         = (st_reg.xfer == XFER_SHIFT);
    assign edge_rise        = master ? (shifting & tick & ~st_reg.bit_clk)
                                     : (slave_en & st_reg.sclk_s2 & ~st_reg.sclk_s3);
    assign edge_fall        = master ? (shifting & tick & st_reg.bit_clk)
                                     : (slave_en & shifting & ~st_reg.sclk_s2 & st_reg.sclk_s3);
    assign rx_in            = st_reg.loopback_enable ? st_reg.tx_shift[7] : st_reg.din_s2;
    assign rx_sampled       = {st_reg.rx_shift[6:0], rx_in};
    assign char_last        = seven_bit_select ? spi_port_pkg::CHAR_LAST_7 : spi_port_pkg::CHAR_LAST_8;
    assign acc_done         = i_psel & i_penable & st_reg.pready;
    assign wr               = acc_done & i_pwrite;
    assign rd               = acc_done & ~i_pwrite;
    assign pending          = st_reg.irq_flag & st_reg.irq_en;
    assign iv_code          = pending[spi_port_pkg::IFG_RX_BIT] ? spi_port_pkg::IV_RX
                           : (pending[spi_port_pkg::IFG_TX_BIT] ? spi_port_pkg::IV_TX
                           : spi_port_pkg::IV_NONE);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;

        st_next.sclk_s1 = i_sclk;
        st_next.sclk_s2 = st_reg.sclk_s1;
        st_next.sclk_s3 = st_reg.sclk_s2;
        st_next.din_s1  = i_data_in;
        st_next.din_s2  = st_reg.din_s1;
        st_next.ste_s1  = i_ste;
        st_next.ste_s2  = st_reg.ste_s1;

        // read mux
        rd_val = 16'h0000;
        if (reg_hit(i_paddr, spi_port_pkg::IDX_CTL)) begin
            rd_val = st_reg.ctl;
        end else if (reg_hit(i_paddr, spi_port_pkg::IDX_RATE)) begin
            rd_val = st_reg.bit_clock_divider;
        end else if (reg_hit(i_paddr, spi_port_pkg::IDX_STAT)) begin
            rd_val = {8'h00, st_reg.loopback_enable, st_reg.bus_conflict_flag, st_reg.overrun_flag,
                      st_reg.stat_spare, st_reg.busy};
        end else if (reg_hit(i_paddr, spi_port_pkg::IDX_RXBUF)) begin
            rd_val = {8'h00, st_reg.rx_char};
        end else if (reg_hit(i_paddr, spi_port_pkg::IDX_TXBUF)) begin
            rd_val = {8'h00, st_reg.tx_char};
        end else if (reg_hit(i_paddr, spi_port_pkg::IDX_IE)) begin
            rd_val = {14'h0000, st_reg.irq_en};
        end else if (reg_hit(i_paddr, spi_port_pkg::IDX_IFG)) begin
            rd_val = {14'h0000, st_reg.irq_flag};
        end else if (reg_hit(i_paddr, spi_port_pkg::IDX_IV)) begin
            rd_val = iv_code;
        end

        // bus answer one cycle into the access phase
        st_next.pready  = i_psel & i_penable & ~st_reg.pready;
        st_next.prdata  = st_next.pready ? {16'h0000, rd_val} : 32'h0000_0000;
        st_next.pslverr = st_next.pready & ~reg_mapped(i_paddr);

        // software writes
        if (wr && reg_hit(i_paddr, spi_port_pkg::IDX_CTL)) begin
            if (soft_hold) begin
                st_next.ctl = i_pwdata[15:0] & spi_port_pkg::CTL_WRITE_MASK;
            end else begin
                st_next.ctl[spi_port_pkg::CTL_SOFT_RESET_BIT] = i_pwdata[spi_port_pkg::CTL_SOFT_RESET_BIT];
            end
        end
        if (wr && soft_hold && reg_hit(i_paddr, spi_port_pkg::IDX_RATE)) begin
            st_next.bit_clock_divider = i_pwdata[15:0];
        end
        if (wr && soft_hold && reg_hit(i_paddr, spi_port_pkg::IDX_STAT)) begin
            st_next.loopback_enable   = i_pwdata[spi_port_pkg::STAT_LOOPBACK_BIT];
            st_next.bus_conflict_flag = i_pwdata[spi_port_pkg::STAT_CONFLICT_BIT];
            st_next.overrun_flag      = i_pwdata[spi_port_pkg::STAT_OVERRUN_BIT];
            st_next.stat_spare        = i_pwdata[spi_port_pkg::STAT_SPARE_LSB +: 4];
        end
        if (wr && reg_hit(i_paddr, spi_port_pkg::IDX_IE)) begin
            st_next.irq_en = i_pwdata[1:0];
        end
        if (wr && reg_hit(i_paddr, spi_port_pkg::IDX_IFG)) begin
            st_next.irq_flag = i_pwdata[1:0];
        end
        if (wr && reg_hit(i_paddr, spi_port_pkg::IDX_TXBUF)) begin
            st_next.tx_char   = seven_bit_select ? {1'b0, i_pwdata[6:0]} : i_pwdata[7:0];
            st_next.tx_loaded = 1'b1;
            st_next.irq_flag[spi_port_pkg::IFG_TX_BIT] = 1'b0;
        end

        // access side effects: RXBUF on reads, IV on any access
        if (rd && reg_hit(i_paddr, spi_port_pkg::IDX_RXBUF)) begin
            st_next.overrun_flag      = 1'b0;
            st_next.bus_conflict_flag = 1'b0;
            st_next.irq_flag[spi_port_pkg::IFG_RX_BIT] = 1'b0;
        end
        if (acc_done && reg_hit(i_paddr, spi_port_pkg::IDX_IV)) begin
            if (pending[spi_port_pkg::IFG_RX_BIT]) begin
                st_next.irq_flag[spi_port_pkg::IFG_RX_BIT] = 1'b0;
            end else if (pending[spi_port_pkg::IFG_TX_BIT]) begin
                st_next.irq_flag[spi_port_pkg::IFG_TX_BIT] = 1'b0;
            end
        end

        // shift engine; flag sets come after the clears so a set wins
        if (master && !shifting) begin
            st_next.div_cnt = 16'h0000;
            st_next.bit_clk = 1'b0;
        end else if (master) begin
            st_next.div_cnt = tick ? 16'h0000 : st_reg.div_cnt + 16'h0001;
        end
        // a write in the load cycle replaces the queued char, so it is never lost
        if (!shifting && st_reg.bit_cnt == 4'h0 && st_reg.tx_loaded && (master || !edge_rise)
            && !(wr && reg_hit(i_paddr, spi_port_pkg::IDX_TXBUF))) begin
            st_next.tx_shift  = seven_bit_select ? {st_reg.tx_char[6:0], 1'b0} : st_reg.tx_char;
            st_next.tx_loaded = 1'b0;
            st_next.irq_flag[spi_port_pkg::IFG_TX_BIT] = 1'b1;
            if (master) begin
                st_next.xfer = XFER_SHIFT;
            end
        end
        if (edge_rise) begin
            st_next.bit_clk  = 1'b1;
            st_next.rx_shift = rx_sampled;
            st_next.xfer     = XFER_SHIFT;
        end
        if (edge_fall) begin
            st_next.bit_clk = 1'b0;
            if (st_reg.bit_cnt == char_last) begin
                st_next.xfer    = XFER_IDLE;
                st_next.bit_cnt = 4'h0;
                st_next.rx_char = seven_bit_select ? {1'b0, st_reg.rx_shift[6:0]}
                                                   : st_reg.rx_shift;
                if (st_next.irq_flag[spi_port_pkg::IFG_RX_BIT]) begin
                    st_next.overrun_flag = 1'b1;
                end
                st_next.irq_flag[spi_port_pkg::IFG_RX_BIT] = 1'b1;
            end else begin
                st_next.tx_shift = {st_reg.tx_shift[6:0], 1'b0};
                st_next.bit_cnt  = st_reg.bit_cnt + 4'h1;
            end
        end
        // deselected slave drops a partial character
        if (!master && !slave_en) begin
            st_next.xfer    = XFER_IDLE;
            st_next.bit_cnt = 4'h0;
        end
        if (conflict_now) begin
            st_next.bus_conflict_flag = 1'b1;
        end

        // hold bit parks the port logic
        if (st_next.ctl[spi_port_pkg::CTL_SOFT_RESET_BIT]) begin
            st_next.xfer      = XFER_IDLE;
            st_next.bit_cnt   = 4'h0;
            st_next.div_cnt   = 16'h0000;
            st_next.bit_clk   = 1'b0;
            st_next.tx_loaded = 1'b0;
            st_next.irq_flag  = spi_port_pkg::IFG_RESET;
        end

        // registered outputs
        st_next.busy     = (st_next.xfer == XFER_SHIFT);
        st_next.irq      = |(st_next.irq_flag & st_next.irq_en);
        st_next.sclk_out = st_next.bit_clk & master;
        st_next.sclk_oe  = master & ~st_next.ctl[spi_port_pkg::CTL_SOFT_RESET_BIT];
        st_next.dout     = st_next.tx_shift[7];
        st_next.dout_oe  = ~st_next.ctl[spi_port_pkg::CTL_SOFT_RESET_BIT] & (master | slave_en);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_prdata          = st_reg.prdata;
    assign o_pready          = st_reg.pready;
    assign o_pslverr         = st_reg.pslverr;
    assign o_sclk            = st_reg.sclk_out;
    assign o_sclk_oe         = st_reg.sclk_oe;
    assign o_data_out        = st_reg.dout;
    assign o_data_oe         = st_reg.dout_oe;
    assign o_transfer_active = st_reg.busy;
    assign o_irq_request     = st_reg.irq;

endmodule // spi_port

// File: verif/spi_port_props.sv
`timescale 1ns/1ps
module spi_port_props (
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic [31:0] o_prdata,
    input  wire logic        o_pready,
    input  wire logic        o_pslverr,
    input  wire logic        o_sclk,
    input  wire logic        o_data_out,
    input  wire logic        o_transfer_active,
    input  wire logic        o_irq_request
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------
    a_ready_pulse: assert property (o_pready |=> !o_pready) else $error("ready held past one cycle");
    a_ready_answer: assert property (i_psel && i_penable && !o_pready |=> o_pready) else $error("late ready");
    a_rdata_idle: assert property (!o_pready |-> o_prdata == 32'h0) else $error("read data outside access");
    a_upper_zero: assert property (o_pready |-> o_prdata[31:16] == 16'h0) else $error("upper bits set");
    a_err_ready: assert property (o_pslverr |-> o_pready) else $error("error without ready");
    a_irq_reset: assert property ($rose(i_rst_b) |-> !o_irq_request) else $error("irq after reset");
    // ------------------------------------------------------------
    // serial side
    // ------------------------------------------------------------
    a_sclk_busy: assert property (o_sclk |-> o_transfer_active) else $error("clock without busy");
    a_busy_min: assert property ($rose(o_transfer_active) |-> o_transfer_active [*8]) else $error("short busy");
    // data never moves while the bit clock stays high
    a_data_steady: assert property (o_sclk && $past(o_sclk) |-> $stable(o_data_out)) else $error("data moved");
    a_busy_end: assert property ($fell(o_transfer_active) |-> !o_sclk) else $error("busy fell, clock high");
    c_frame: cover property ($rose(o_transfer_active));
    c_slverr: cover property (o_pslverr);
    c_irq: cover property (o_irq_request);
endmodule // spi_port_props

bind spi_port spi_port_props u_props (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(i_psel), .i_penable(i_penable),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_sclk(o_sclk), .o_data_out(o_data_out),
    .o_transfer_active(o_transfer_active), .o_irq_request(o_irq_request));

// File: verif/spi_peer.sv
`timescale 1ns/1ps
module spi_peer (
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_sclk,
    input  wire logic       i_mosi,
    input  wire logic       i_load,
    input  wire logic [7:0] i_reply,
    output logic            o_miso,
    output logic [7:0]      o_rx_char
);
    logic [7:0] out_reg;
    logic       sclk_reg;
    // slave peer: samples on rise, shifts on fall, msb first
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            out_reg   <= 8'h00;
            sclk_reg  <= 1'b0;
            o_rx_char <= 8'h00;
        end else begin
            sclk_reg <= i_sclk;
            if (i_load) out_reg <= i_reply;
            // past the frame the line keeps changing, never a stale bit
            else if (sclk_reg && !i_sclk) out_reg <= {out_reg[6:0], ~out_reg[0]};
            if (!sclk_reg && i_sclk) o_rx_char <= {o_rx_char[6:0], i_mosi};
        end
    end
    assign o_miso = out_reg[7];
endmodule // spi_peer

// File: verif/spi_port_test.sv
`timescale 1ns/1ps
module spi_port_test;
    logic        clk = 1'b0, rst_b, psel, penable, pwrite, ste, load, miso;
    logic [7:0]  paddr, reply, peer_rx;
    logic [31:0] pwdata, prdata, r;
    logic        pready, pslverr, sclk_out, sclk_oe, data_out, data_oe, busy, irq, e;
    int          fail_count = 0, num_checks = 0;
    always #5 clk = ~clk;
    spi_port DUT (.i_clk(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_sclk(1'b0), .i_data_in(miso), .i_ste(ste), .o_sclk(sclk_out), .o_sclk_oe(sclk_oe),
        .o_data_out(data_out), .o_data_oe(data_oe), .o_transfer_active(busy), .o_irq_request(irq));
    spi_peer peer (.i_clk(clk), .i_rst_b(rst_b), .i_sclk(sclk_out), .i_mosi(data_out), .i_load(load),
        .i_reply(reply), .o_miso(miso), .o_rx_char(peer_rx));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [5:0] idx, input logic [15:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= {16'h0000, wd};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
        if (n >= 50) check(32'h0, 32'h1, "no ready");
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] idx, input logic [15:0] d);
        apb(1'b1, idx, d, r, e);
    endtask
    task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 16'h0000, r, e);
        check(r, exp, "read data");
    endtask
    // counts cycles between two rises of the bit clock
    task automatic period_chk(input logic [31:0] exp);
        int n;
        logic p;
        n = 0;
        p = 1'b1;
        while (!(p === 1'b0 && sclk_out === 1'b1) && n < 500) begin p = sclk_out; @(posedge clk); n++; end
        n = 0;
        do begin p = sclk_out; @(posedge clk); n++; end while (!(p === 1'b0 && sclk_out === 1'b1) && n < 500);
        check(n, exp, "bit clock period");
    endtask
    task automatic frame(input logic [7:0] rep, input logic [15:0] tx, input logic [31:0] per);
        int n;
        @(posedge clk);
        load  <= 1'b1;
        reply <= rep;
        @(posedge clk);
        load  <= 1'b0;
        wr(spi_port_pkg::IDX_TXBUF, tx);
        period_chk(per);
        n = 0;
        while (busy !== 1'b0 && n < 2000) begin @(posedge clk); n++; end
        check({31'h0, busy}, 32'h0, "busy stuck");
        repeat (3) @(posedge clk);
    endtask
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        {rst_b, psel, penable, pwrite, load, paddr, reply, pwdata} = '0;
        ste = 1'b1;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd(spi_port_pkg::IDX_CTL, 32'h0001);
        check({30'h0, sclk_oe, data_oe}, 32'h0, "pins under hold");
        rd(spi_port_pkg::IDX_RATE, 32'h0000);
        rd(spi_port_pkg::IDX_STAT, 32'h0000);
        rd(spi_port_pkg::IDX_IE, 32'h0000);
        rd(spi_port_pkg::IDX_IFG, 32'h0002);
        rd(spi_port_pkg::IDX_IV, 32'h0000);
        apb(1'b0, 6'h01, 16'h0000, r, e);
        check({31'h0, e}, 32'h1, "unmapped access");
        wr(spi_port_pkg::IDX_RATE, 16'h0008);
        rd(spi_port_pkg::IDX_RATE, 32'h0008);
        wr(spi_port_pkg::IDX_CTL, 16'h2900);
        wr(spi_port_pkg::IDX_RATE, 16'h1234);
        rd(spi_port_pkg::IDX_RATE, 32'h0008);
        check({30'h0, sclk_oe, data_oe}, 32'h3, "master pins");
        rd(spi_port_pkg::IDX_STAT, 32'h0000);
        wr(spi_port_pkg::IDX_IE, 16'h0003);
        rd(spi_port_pkg::IDX_IE, 32'h0003);
        check({31'h0, irq}, 32'h1, "irq with tx flag");
        rd(spi_port_pkg::IDX_IV, 32'h0004);
        rd(spi_port_pkg::IDX_IFG, 32'h0000);
        check({31'h0, irq}, 32'h0, "irq after vector");
        @(posedge clk);
        load  <= 1'b1;
        reply <= 8'hA5;
        @(posedge clk);
        load  <= 1'b0;
        wr(spi_port_pkg::IDX_TXBUF, 16'h003C);
        rd(spi_port_pkg::IDX_STAT, 32'h0001);
        // let the first character finish before the next frame queues
        repeat (200) @(posedge clk);
        check({31'h0, busy}, 32'h0, "first frame busy");
        rd(spi_port_pkg::IDX_RXBUF, 32'h00A5);
        frame(8'h5A, 16'h00C3, 32'd16);
        check({24'h0, peer_rx}, 32'h00C3, "peer got");
        rd(spi_port_pkg::IDX_IFG, 32'h0003);
        rd(spi_port_pkg::IDX_IV, 32'h0002);
        rd(spi_port_pkg::IDX_IFG, 32'h0002);
        rd(spi_port_pkg::IDX_RXBUF, 32'h005A);
        // overrun is cleared by the RXBUF read here, not by a STAT write
        frame(8'h11, 16'h0001, 32'd16);
        frame(8'h22, 16'h0002, 32'd16);
        rd(spi_port_pkg::IDX_STAT, 32'h0020);
        rd(spi_port_pkg::IDX_RXBUF, 32'h0022);
        rd(spi_port_pkg::IDX_STAT, 32'h0000);
        rd(spi_port_pkg::IDX_IFG, 32'h0002);
        wr(spi_port_pkg::IDX_CTL, 16'h0001);
        wr(spi_port_pkg::IDX_RATE, 16'h0000);
        wr(spi_port_pkg::IDX_STAT, 16'h0080);
        rd(spi_port_pkg::IDX_STAT, 32'h0080);
        wr(spi_port_pkg::IDX_CTL, 16'h3900);
        frame(8'h00, 16'h00D5, 32'd2);
        rd(spi_port_pkg::IDX_RXBUF, 32'h0055);
        wr(spi_port_pkg::IDX_CTL, 16'h0001);
        wr(spi_port_pkg::IDX_STAT, 16'h0000);
        wr(spi_port_pkg::IDX_CTL, 16'h2B00);
        rd(spi_port_pkg::IDX_STAT, 32'h0040);
        wr(spi_port_pkg::IDX_CTL, 16'h0001);
        wr(spi_port_pkg::IDX_STAT, 16'h0000);
        wr(spi_port_pkg::IDX_CTL, 16'h2500);
        rd(spi_port_pkg::IDX_STAT, 32'h0000);
        check({30'h0, sclk_oe, data_oe}, 32'h0, "deselected slave pins");
        stop_test();
    end
    // the full sequence needs about a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        $display("BAD %0t watchdog expired", $time);
        stop_test();
    end
endmodule // spi_port_test
